// >>> core/bstap_pkg.sv
// Shared constants and types of the boundary-scan test port.
package bstap_pkg;
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W = 109;
    localparam int OE_CELL = 108;
    localparam int RESET_TMS_EDGES = 5;
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_IDCODE = 3'h1;
    localparam logic [2:0] IR_SAMPLEZ = 3'h2;
    localparam logic [2:0] IR_SAMPLE = 3'h4;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    // Arbitrary identification word, not tied to any maker.
    localparam logic [31:0] ID_WORD = 32'h1234_5679;
    localparam int BUF_DEPTH = 2;
    typedef enum logic [3:0] {
        TlReset, RunIdle, SelDr, CapDr, ShDr, Ex1Dr, PauDr, Ex2Dr, UpdDr,
        SelIr, CapIr, ShIr, Ex1Ir, PauIr, Ex2Ir, UpdIr
    } bstap_state_e;
endpackage : bstap_pkg

// >>> core/bstap_top.sv
// Boundary-scan test access port sampled on the system clock.
// How it works
// RQ1: Power-up leaves the port in test reset without touching memory pins.
// RQ2: Mode select and serial data are taken on test-clock rising edges.
// RQ3: Serial data output changes only on test-clock falling edges.
// RQ4: Mode select steers the controller at each rising edge.
// RQ5: Undriven mode select and data inputs read as logic high.
// RQ6: Serial input enters the MSB of the selected register.
// RQ7: Serial output shows the LSB; data shifts toward LSB.
// RQ8: Output driver enabled only in shift states, otherwise floated.
// RQ9: Five rising edges with mode select high reach test reset.
// RQ10: Test reset never alters memory function, allowed at any time.
// RQ11: Power-up resets the controller so serial output starts floated.
// RQ12: Exactly one register sits in the serial path, chosen by instruction.
// RQ13: Instruction register is three bits, loaded serially.
// RQ14: Instruction is identification after power-up and test reset.
// RQ15: Instruction capture loads 01 into the two low bits.
// RQ16: One-bit bypass register, cleared when bypass executes.
// RQ17: Scan chain has a cell per pin plus reserved cells.
// RQ18: Data capture samples pin ring; data shift puts chain in path.
// RQ19: Pin capture happens under extest, sample and sample-float.
// RQ20: Each scan cell maps to exactly one package ball.
// RQ21: Identification instruction captures and shifts a 32-bit word.
// RQ22: New instruction takes effect only at instruction update.
// RQ23: Sample-float holds output bus floated until next update.
// RQ24: Cell 108 enables outputs under extest; preset high at reset.
// RQ25: Standard sixteen-state controller driven by mode select.
// RQ26: Unknown instruction codes select the bypass path.
`timescale 1ns/1ps
module bstap_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tmsDrive,
    input wire logic tdi,
    input wire logic tdiDrive,
    input wire logic [108:0] pinRing,
    input wire logic obsReady,
    output logic tdoOut,
    output logic tdoOe,
    output logic [108:0] pinDrive,
    output logic extestActive,
    output logic outBusEnable,
    output logic obsValid,
    output logic obsBit,
    output logic tdiReady
);
    logic rstMeta;
    logic rstSync;
    logic [2:0] tckS;
    logic [2:0] tmsS;
    logic [2:0] tdiS;
    logic tckLvl_q;
    logic tmsLvl_q;
    logic tdiLvl_q;
    logic [2:0] ir_q;
    logic [2:0] irShift_q;
    logic bypass_q;
    logic [31:0] idShift_q;
    logic [108:0] bsr_q;
    logic [108:0] preload_q;
    logic tdo_q;
    logic tdoOe_q;
    logic floatZ_q;
    logic [3:0] bufData_q;
    logic [1:0] bufValid_q;
    bstap_pkg::bstap_state_e state_q;
    bstap_pkg::bstap_state_e state_d;

    // The first stage of each synchroniser feeds only the second.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // RQ5 pull-up view
    wire tmsPin = tmsDrive ? tms : 1'b1;
    wire tdiPin = tdiDrive ? tdi : 1'b1;

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            tckS <= 3'h0;
            tmsS <= 3'h7;
            tdiS <= 3'h7;
        end else begin
            tckS <= {tckS[1:0], tck};
            tmsS <= {tmsS[1:0], tmsPin};
            tdiS <= {tdiS[1:0], tdiPin};
        end
    end

    // A level moves only once the second and third stages agree.
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            tckLvl_q <= 1'b0;
            tmsLvl_q <= 1'b1;
            tdiLvl_q <= 1'b1;
        end else begin
            if (tckS[1] == tckS[2]) tckLvl_q <= tckS[2];
            if (tmsS[1] == tmsS[2]) tmsLvl_q <= tmsS[2];
            if (tdiS[1] == tdiS[2]) tdiLvl_q <= tdiS[2];
        end
    end

    // RQ2 rising edge sample
    wire tckRise = (tckS[1] == tckS[2]) && tckS[2] && !tckLvl_q;
    // RQ3 falling edge drive
    wire tckFall = (tckS[1] == tckS[2]) && !tckS[2] && tckLvl_q;

    // Each edge's mode and data pair waits here until the observer is
    // ready, so a stall of up to two edges loses nothing; a third edge
    // during a stall is dropped, so the tester must watch tdiReady.
    // Steps are kept a cycle apart so that every step pulse stays single.
    wire shiftTake = bufValid_q[0] && obsReady && !obsValid;
    wire bufPush = tckRise && !bufValid_q[1];
    wire bufPop = shiftTake;
    wire [1:0] edgePair = {tmsLvl_q, tdiLvl_q};

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            bufData_q <= 4'h0;
            bufValid_q <= 2'h0;
        end else begin
            case ({bufPush, bufPop})
                2'b10: begin
                    if (bufValid_q[0]) begin
                        bufData_q[3:2] <= edgePair;
                        bufValid_q[1] <= 1'b1;
                    end else begin
                        bufData_q[1:0] <= edgePair;
                        bufValid_q[0] <= 1'b1;
                    end
                end
                2'b01: begin
                    bufData_q <= {2'h0, bufData_q[3:2]};
                    bufValid_q <= {1'b0, bufValid_q[1]};
                end
                2'b11: begin
                    if (bufValid_q[1]) begin
                        bufData_q <= {edgePair, bufData_q[3:2]};
                    end else begin
                        bufData_q[1:0] <= edgePair;
                    end
                end
                default: begin
                    bufData_q <= bufData_q;
                end
            endcase
        end
    end

    // The head entry carries the mode and data bits of the oldest edge.
    wire stepTms = bufData_q[1];
    wire stepTdi = bufData_q[0];
    wire step = shiftTake;

    // RQ4 mode select steers
    // RQ25 sixteen states
    // RQ9 five-high reset
    always_comb begin
        state_d = state_q;
        case (state_q)
            bstap_pkg::TlReset: state_d = stepTms ? bstap_pkg::TlReset
                                                  : bstap_pkg::RunIdle;
            bstap_pkg::RunIdle: state_d = stepTms ? bstap_pkg::SelDr
                                                  : bstap_pkg::RunIdle;
            bstap_pkg::SelDr: state_d = stepTms ? bstap_pkg::SelIr
                                                : bstap_pkg::CapDr;
            bstap_pkg::CapDr: state_d = stepTms ? bstap_pkg::Ex1Dr
                                                : bstap_pkg::ShDr;
            bstap_pkg::ShDr: state_d = stepTms ? bstap_pkg::Ex1Dr
                                               : bstap_pkg::ShDr;
            bstap_pkg::Ex1Dr: state_d = stepTms ? bstap_pkg::UpdDr
                                                : bstap_pkg::PauDr;
            bstap_pkg::PauDr: state_d = stepTms ? bstap_pkg::Ex2Dr
                                                : bstap_pkg::PauDr;
            bstap_pkg::Ex2Dr: state_d = stepTms ? bstap_pkg::UpdDr
                                                : bstap_pkg::ShDr;
            bstap_pkg::UpdDr: state_d = stepTms ? bstap_pkg::SelDr
                                                : bstap_pkg::RunIdle;
            bstap_pkg::SelIr: state_d = stepTms ? bstap_pkg::TlReset
                                                : bstap_pkg::CapIr;
            bstap_pkg::CapIr: state_d = stepTms ? bstap_pkg::Ex1Ir
                                                : bstap_pkg::ShIr;
            bstap_pkg::ShIr: state_d = stepTms ? bstap_pkg::Ex1Ir
                                               : bstap_pkg::ShIr;
            bstap_pkg::Ex1Ir: state_d = stepTms ? bstap_pkg::UpdIr
                                                : bstap_pkg::PauIr;
            bstap_pkg::PauIr: state_d = stepTms ? bstap_pkg::Ex2Ir
                                                : bstap_pkg::PauIr;
            bstap_pkg::Ex2Ir: state_d = stepTms ? bstap_pkg::UpdIr
                                                : bstap_pkg::ShIr;
            bstap_pkg::UpdIr: state_d = stepTms ? bstap_pkg::SelDr
                                                : bstap_pkg::RunIdle;
            default: state_d = bstap_pkg::TlReset;
        endcase
    end

    // RQ12 one selected register
    // RQ26 unknown codes bypass
    wire selBsr = (ir_q == bstap_pkg::IR_EXTEST)
        || (ir_q == bstap_pkg::IR_SAMPLE) || (ir_q == bstap_pkg::IR_SAMPLEZ);
    wire selId = (ir_q == bstap_pkg::IR_IDCODE);
    wire enterTlr = step && (state_d == bstap_pkg::TlReset);
    wire dataLsb = selBsr ? bsr_q[0] : (selId ? idShift_q[0] : bypass_q);
    wire tdoNext = (state_q == bstap_pkg::ShIr) ? irShift_q[0] : dataLsb;
    // RQ8 drive only while shifting
    wire shiftNow = (state_q == bstap_pkg::ShIr)
        || (state_q == bstap_pkg::ShDr);

    // RQ1 power-up reset
    // RQ11 starts in test reset
    // RQ10 memory unaffected
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            state_q <= bstap_pkg::TlReset;
        end else if (step) begin
            state_q <= state_d;
        end
    end

    // RQ13 three-bit shift
    // RQ14 identification default
    // RQ15 capture loads 01
    // RQ22 update applies instruction
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            ir_q <= bstap_pkg::IR_IDCODE;
            irShift_q <= bstap_pkg::IR_IDCODE;
        end else if (enterTlr) begin
            ir_q <= bstap_pkg::IR_IDCODE;
        end else if (step) begin
            case (state_q)
                bstap_pkg::CapIr: irShift_q <= {1'b0, bstap_pkg::IR_CAPTURE};
                bstap_pkg::ShIr: irShift_q <= {stepTdi, irShift_q[2:1]};
                bstap_pkg::UpdIr: ir_q <= irShift_q;
                default: irShift_q <= irShift_q;
            endcase
        end
    end

    // RQ6 enter at MSB
    // RQ7 shift toward LSB
    // RQ16 bypass cleared on capture
    // RQ18 capture then shift
    // RQ19 capture under three codes
    // RQ21 identification word
    // RQ17 full pin ring
    // RQ20 one cell per ball
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            bypass_q <= 1'b0;
            idShift_q <= 32'h0;
            bsr_q <= 109'h0;
        end else if (step && state_q == bstap_pkg::CapDr) begin
            bypass_q <= 1'b0;
            if (selId) idShift_q <= bstap_pkg::ID_WORD;
            if (selBsr) bsr_q <= pinRing;
        end else if (step && state_q == bstap_pkg::ShDr) begin
            if (selBsr) bsr_q <= {stepTdi, bsr_q[108:1]};
            else if (selId) idShift_q <= {stepTdi, idShift_q[31:1]};
            else bypass_q <= stepTdi;
        end
    end

    // RQ24 output enable cell
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            preload_q <= {1'b1, 108'h0};
        end else if (enterTlr) begin
            preload_q[bstap_pkg::OE_CELL] <= 1'b1;
        end else if (step && state_q == bstap_pkg::UpdDr && selBsr) begin
            preload_q <= bsr_q;
        end
    end

    // RQ23 float until next update
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            floatZ_q <= 1'b0;
        end else if (enterTlr) begin
            floatZ_q <= 1'b0;
        end else if (step && state_q == bstap_pkg::UpdIr) begin
            floatZ_q <= (irShift_q == bstap_pkg::IR_SAMPLEZ);
        end
    end

    // RQ3 falling edge output
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            tdo_q <= 1'b0;
            tdoOe_q <= 1'b0;
        end else if (tckFall) begin
            tdo_q <= tdoNext;
            tdoOe_q <= shiftNow;
        end
    end

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            tdoOut <= 1'b0;
            tdoOe <= 1'b0;
            pinDrive <= {1'b1, 108'h0};
            extestActive <= 1'b0;
            outBusEnable <= 1'b1;
            obsValid <= 1'b0;
            obsBit <= 1'b0;
            tdiReady <= 1'b1;
        end else begin
            tdoOut <= tdo_q;
            tdoOe <= tdoOe_q;
            pinDrive <= preload_q;
            extestActive <= (ir_q == bstap_pkg::IR_EXTEST);
            outBusEnable <= !floatZ_q && ((ir_q != bstap_pkg::IR_EXTEST)
                || preload_q[bstap_pkg::OE_CELL]);
            obsValid <= step;
            obsBit <= stepTms;
            tdiReady <= !bufValid_q[1];
        end
    end
endmodule : bstap_top

// >>> test/bstap_chk.sv
// Timing and enable checks on the test port's outputs.
`timescale 1ns/1ps
module bstap_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tmsDrive,
    input wire logic obsReady,
    input wire logic tdoOut,
    input wire logic tdoOe,
    input wire logic [108:0] pinDrive,
    input wire logic extestActive,
    input wire logic outBusEnable,
    input wire logic obsValid,
    input wire logic obsBit,
    input wire logic tdiReady
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_tdo_on_fall: assert property (
        $changed(tdoOut) |-> !tck && !$past(tck, 2))
        else $error("serial out moved outside a low test clock phase");
    a_oe_on_fall: assert property (
        $changed(tdoOe) |-> !tck && !$past(tck, 2))
        else $error("output enable moved outside a low test clock phase");
    a_obs_single: assert property (obsValid |=> !obsValid)
        else $error("step pulse longer than one cycle");
    a_obs_mode_bit: assert property (
        obsReady[*8] ##0 obsValid |-> obsBit == (tms || !tmsDrive))
        else $error("step bit differs from mode select");
    a_buf_drains: assert property (obsReady[*3] |-> tdiReady)
        else $error("edge buffer full while observer ready");
    a_rst_floated: assert property (
        $rose(rst_n) |-> !tdoOe && outBusEnable && pinDrive[108])
        else $error("reset values wrong at release");
    a_ext_floats: assert property (
        (extestActive && !pinDrive[108])[*3] |-> !outBusEnable)
        else $error("output bus driven with enable cell low");
    a_ext_drives: assert property (
        (extestActive && pinDrive[108])[*3] |-> outBusEnable)
        else $error("output bus floated with enable cell high");
    c_shift: cover property (obsValid && tdoOe);
    c_float: cover property (extestActive && !outBusEnable);
    c_full: cover property (!tdiReady);
endmodule : bstap_chk

bind bstap_top bstap_chk u_chk (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms),
    .tmsDrive(tmsDrive), .obsReady(obsReady), .tdoOut(tdoOut), .tdoOe(tdoOe),
    .pinDrive(pinDrive), .extestActive(extestActive),
    .outBusEnable(outBusEnable), .obsValid(obsValid), .obsBit(obsBit),
    .tdiReady(tdiReady));

// >>> test/bstap_tester.sv
// Tester model that clocks the test port one frame at a time.
`timescale 1ns/1ps
module bstap_tester (
    input wire logic clk,
    input wire logic tdoOut,
    input wire logic tdoOe,
    output logic tck,
    output logic tms,
    output logic tmsDrive,
    output logic tdi,
    output logic tdiDrive
);
    logic lastTdo = 1'b0;
    logic tdoLine;
    // A floated serial out shows the inverse so a stale value cannot match.
    assign tdoLine = tdoOe ? tdoOut : ~lastTdo;
    always @(posedge clk) if (tdoOe) lastTdo <= tdoOut;
    initial begin
        tck = 1'b0;
        tms = 1'b0;
        tmsDrive = 1'b0;
        tdi = 1'b0;
        tdiDrive = 1'b0;
    end
    task automatic step(input logic drv, input logic m, input logic d,
                        output logic o);
        @(posedge clk);
        #1;
        tmsDrive = drv;
        tdiDrive = drv;
        tms = drv ? m : 1'b0;
        tdi = drv ? d : 1'b0;
        repeat (7) @(posedge clk);
        #1;
        tck = 1'b1;
        o = tdoLine;
        repeat (8) @(posedge clk);
        #1;
        tck = 1'b0;
        tmsDrive = 1'b0;
        tdiDrive = 1'b0;
        tms = ~tms;
        tdi = ~tdi;
    endtask : step
    task automatic scan(input logic ir, input int n, input logic [108:0] din,
                        output logic [108:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b1, 1'b1, o);
        if (ir) step(1'b1, 1'b1, 1'b1, o);
        step(1'b1, 1'b0, 1'b1, o);
        step(1'b1, 1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            step(1'b1, i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b1, 1'b1, o);
        step(1'b1, 1'b0, 1'b1, o);
    endtask : scan
endmodule : bstap_tester

// >>> test/tb_bstap_top.sv
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/1ps
module tb_bstap_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic obsReady = 1'b1;
    logic [108:0] pinRing = 109'h1_2345_6789_abcd_ef01_2345_6789;
    logic tck, tms, tmsDrive, tdi, tdiDrive, tdoOut, tdoOe;
    logic extestActive, outBusEnable, obsValid, obsBit, tdiReady;
    logic [108:0] pinDrive, d;
    logic o;
    int miscompares = 0;
    int samples_checked = 0;
    bstap_top uut (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms),
        .tmsDrive(tmsDrive), .tdi(tdi), .tdiDrive(tdiDrive),
        .pinRing(pinRing), .obsReady(obsReady), .tdoOut(tdoOut),
        .tdoOe(tdoOe), .pinDrive(pinDrive), .extestActive(extestActive),
        .outBusEnable(outBusEnable), .obsValid(obsValid), .obsBit(obsBit),
        .tdiReady(tdiReady));
    bstap_tester u_tst (.clk(clk), .tdoOut(tdoOut), .tdoOe(tdoOe),
        .tck(tck), .tms(tms), .tmsDrive(tmsDrive), .tdi(tdi),
        .tdiDrive(tdiDrive));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic check(input string what, input logic [108:0] seen,
                         input logic [108:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run;
        $display("checked %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic load(input logic [2:0] code);
        u_tst.scan(1'b1, 3, {106'h0, code}, d);
        check("ir capture", d[1:0], bstap_pkg::IR_CAPTURE);
    endtask : load
    task automatic t_idcode;
        u_tst.step(1'b1, 1'b0, 1'b1, o);
        u_tst.scan(1'b0, 32, '0, d);
        check("id word", d[31:0], bstap_pkg::ID_WORD);
        check("oe idle", tdoOe, 1'b0);
    endtask : t_idcode
    task automatic t_bypass;
        logic [2:0] codes [4] = '{3'h3, 3'h5, 3'h6, bstap_pkg::IR_BYPASS};
        foreach (codes[k]) begin
            load(codes[k]);
            u_tst.scan(1'b0, 8, 109'h0b5, d);
            check("bypass path", d[7:0], 8'h6a);
        end
    endtask : t_bypass
    task automatic t_chain;
        logic [108:0] din;
        din = 109'h0_f0e1_d2c3_b4a5_9687_7869_5a4b;
        load(bstap_pkg::IR_SAMPLE);
        u_tst.scan(1'b0, bstap_pkg::BSR_W, din, d);
        check("pin capture", d, pinRing);
        check("preload", pinDrive, din);
        load(bstap_pkg::IR_EXTEST);
        check("extest flag", extestActive, 1'b1);
        check("bus floated", outBusEnable, 1'b0);
        load(bstap_pkg::IR_SAMPLEZ);
        check("samplez float", outBusEnable, 1'b0);
    endtask : t_chain
    task automatic t_float_reset;
        repeat (bstap_pkg::RESET_TMS_EDGES) u_tst.step(1'b0, 1'b0, 1'b0, o);
        check("bus after reset", outBusEnable, 1'b1);
        check("cell preset", pinDrive[108], 1'b1);
        t_idcode();
    endtask : t_float_reset
    task automatic t_stall;
        int n;
        int pulses;
        obsReady = 1'b0;
        repeat (2) u_tst.step(1'b1, 1'b0, 1'b1, o);
        check("buffer full", tdiReady, 1'b0);
        @(posedge clk);
        #1;
        obsReady = 1'b1;
        pulses = 0;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            #1;
            if (obsValid === 1'b1) pulses++;
        end
        check("buffer drained", tdiReady, 1'b1);
        check("held steps", pulses, 2);
        t_idcode();
    endtask : t_stall
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (10) @(posedge clk);
        check("oe reset", tdoOe, 1'b0);
        check("bus reset", outBusEnable, 1'b1);
        check("cell reset", pinDrive[108], 1'b1);
        t_idcode();
        t_bypass();
        t_chain();
        t_float_reset();
        t_stall();
        complete_run();
    end
endmodule : tb_bstap_top
